// ---- hw/exec_pkg.sv ----
// Constants, bus carriers and state encodings for the instruction execute block
package exec_pkg;

    // Register byte offsets
    localparam logic [5:0] INSN_OFS = 6'h00;
    localparam logic [5:0] WORK_OFS = 6'h04;
    localparam logic [5:0] STATUS_OFS = 6'h08;
    localparam logic [5:0] INTCTL_OFS = 6'h0c;
    localparam logic [5:0] PC_OFS = 6'h10;
    localparam logic [5:0] STACK_OFS = 6'h14;
    localparam logic [5:0] FILE_ADDR_OFS = 6'h18;
    localparam logic [5:0] FILE_DATA_OFS = 6'h1c;
    localparam logic [5:0] WATCHDOG_OFS = 6'h20;
    localparam logic [5:0] WAKE_OFS = 6'h24;

    // Status register fields, INT_ENABLE_BIT sits in the interrupt control register
    localparam int CARRY_BIT = 0;
    localparam int DIGIT_CARRY_BIT = 1;
    localparam int ZERO_BIT = 2;
    localparam int POWER_DOWN_BIT = 3;
    localparam int TIME_OUT_BIT = 4;
    localparam int BUSY_BIT = 5;
    localparam int SLEEP_BIT = 6;
    localparam int INT_ENABLE_BIT = 7;

    // Reset values
    localparam logic [7:0] WORK_RESET = 8'h00;
    localparam logic [12:0] PC_RESET = 13'h0000;
    localparam logic POWER_DOWN_RESET = 1'b1;
    localparam logic TIME_OUT_RESET = 1'b1;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // Byte oriented opcodes, bits 13:8
    localparam logic [5:0] INCREMENT_FILE_OP = 6'h0a;
    localparam logic [5:0] OR_WORK_WITH_FILE_OP = 6'h04;
    localparam logic [5:0] MOVE_FILE_OP = 6'h08;
    localparam logic [5:0] STORE_WORK_TO_FILE_OP = 6'h00;
    localparam logic [5:0] SUBTRACT_FROM_FILE_OP = 6'h02;
    localparam logic [5:0] NIBBLE_SWAP_OP = 6'h0e;
    localparam logic [5:0] XOR_WORK_WITH_FILE_OP = 6'h06;
    localparam logic [5:0] ROTATE_RIGHT_CARRY_OP = 6'h0c;
    // Literal opcodes, matched on their leading bits
    localparam logic [3:0] LOAD_LITERAL_OP = 4'hc;
    localparam logic [3:0] RETURN_WITH_LITERAL_OP = 4'hd;
    localparam logic [4:0] SUBTRACT_FROM_LITERAL_OP = 5'h1e;
    localparam logic [5:0] XOR_LITERAL_OP = 6'h3a;
    // Fixed encodings
    localparam logic [13:0] INTERRUPT_RETURN_OP = 14'h0009;
    localparam logic [13:0] SUBROUTINE_RETURN_OP = 14'h0008;
    localparam logic [13:0] SLEEP_OP = 14'h0063;

    localparam int FILE_DEPTH = 128;
    localparam int FILE_AW = 7;
    localparam int STACK_DEPTH = 8;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_FETCH = 5'h02,
        ST_EXEC = 5'h04,
        ST_SECOND = 5'h08,
        ST_ASLEEP = 5'h10
    } exec_state_t;

    typedef struct packed {
        logic awvalid;
        logic [5:0] awaddr;
        logic [2:0] awprot;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [5:0] araddr;
        logic [2:0] arprot;
        logic rready;
    } axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axi_rsp_t;

endpackage

// ---- hw/file_ram.sv ----
// File register storage with registered read data
`timescale 1ns/10ps
module file_ram (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Write port
    input wire logic we_i,
    input wire logic [exec_pkg::FILE_AW-1:0] waddr_i,
    input wire logic [7:0] wdata_i,
    // Read port
    input wire logic [exec_pkg::FILE_AW-1:0] raddr_i,
    output logic [7:0] rdata_o
);
    import exec_pkg::*;

    typedef struct packed {
        logic [FILE_DEPTH-1:0][7:0] cells;
        logic [7:0] rdata;
    } ram_state_t;

    ram_state_t st;
    ram_state_t next_st;

    always_comb begin
        next_st = st;
        next_st.rdata = st.cells[raddr_i];
        if (we_i) begin
            next_st.cells[waddr_i] = wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rdata_o = st.rdata;
endmodule

// ---- hw/insn_exec_core.sv ----
// Instruction execute core with AXI4-Lite register access
//
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
module insn_exec_core (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_N_I,
    // Register bus
    input wire exec_pkg::axi_req_t AXI_REQ_I,
    output exec_pkg::axi_rsp_t AXI_RSP_O,
    // Core status
    output logic SLEEP_O,
    output logic INT_ENABLE_O
);
    import exec_pkg::*;

    typedef struct packed {
        axi_rsp_t rsp;
        logic aw_held;
        logic [5:0] aw_addr;
        logic w_held;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic [1:0] rd_wait;
        exec_state_t state;
        logic [13:0] insn;
        logic [7:0] work;
        logic carry;
        logic digit_carry;
        logic zero;
        logic power_down_flag_n;
        logic time_out_flag_n;
        logic global_interrupt_enable;
        logic sleeping;
        logic [12:0] pc;
        logic [STACK_DEPTH-1:0][12:0] stack;
        logic [2:0] sp;
        logic [FILE_AW-1:0] file_addr;
        logic [FILE_AW-1:0] mem_addr;
        logic mem_we;
        logic [FILE_AW-1:0] mem_waddr;
        logic [7:0] mem_wdata;
        logic [7:0] watchdog_counter;
        logic [7:0] watchdog_prescale;
    } core_state_t;

    core_state_t st;
    core_state_t next_st;
    logic [7:0] mem_rdata;
    logic [2:0] sp_dec;
    logic [12:0] stack_top;

    file_ram u_file_ram (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .we_i(st.mem_we),
        .waddr_i(st.mem_waddr),
        .wdata_i(st.mem_wdata),
        .raddr_i(st.mem_addr),
        .rdata_o(mem_rdata)
    );

    assign sp_dec = st.sp - 3'd1;
    assign stack_top = st.stack[sp_dec];

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                m[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return m;
    endfunction

    always_comb begin
        logic [31:0] wv;
        logic [31:0] rv;
        logic [1:0] resp;
        logic idle;
        logic [7:0] f;
        logic [7:0] k;
        logic [7:0] res;
        logic to_file;
        logic to_work;
        logic upd_zero;
        logic pop;
        wv = '0;
        rv = '0;
        resp = RESP_OKAY;
        f = mem_rdata;
        k = st.insn[7:0];
        res = '0;
        to_file = 1'b0;
        to_work = 1'b0;
        upd_zero = 1'b0;
        pop = 1'b0;
        idle = (st.state == ST_IDLE);
        next_st = st;
        next_st.mem_we = 1'b0;

        // Watchdog keeps running in sleep, clocked by CLK_I like the rest of the core
        next_st.watchdog_prescale = st.watchdog_prescale + 8'h01;
        if (st.watchdog_prescale == 8'hff) begin
            next_st.watchdog_counter = st.watchdog_counter + 8'h01;
        end

        // Write address and data may arrive in either order
        if (AXI_REQ_I.awvalid && st.rsp.awready) begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = AXI_REQ_I.awaddr;
        end
        if (AXI_REQ_I.wvalid && st.rsp.wready) begin
            next_st.w_held = 1'b1;
            next_st.wdata = AXI_REQ_I.wdata;
            next_st.wstrb = AXI_REQ_I.wstrb;
        end
        if (st.rsp.bvalid && AXI_REQ_I.bready) begin
            next_st.rsp.bvalid = 1'b0;
        end

        if (st.aw_held && st.w_held && !st.rsp.bvalid) begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.rsp.bvalid = 1'b1;
            case (st.aw_addr)
                INSN_OFS: begin
                    // A file read in flight owns the memory address
                    if (idle && st.rd_wait == 2'd0) begin
                        wv = merge({18'h0, st.insn}, st.wdata, st.wstrb);
                        next_st.insn = wv[13:0];
                        next_st.mem_addr = wv[FILE_AW-1:0];
                        next_st.state = ST_FETCH;
                    end else begin
                        resp = RESP_SLVERR;
                    end
                end
                WORK_OFS: begin
                    wv = merge({24'h0, st.work}, st.wdata, st.wstrb);
                    if (idle) next_st.work = wv[7:0];
                    else resp = RESP_SLVERR;
                end
                STATUS_OFS: begin
                    wv = merge({29'h0, st.zero, st.digit_carry, st.carry}, st.wdata, st.wstrb);
                    if (idle) begin
                        next_st.carry = wv[CARRY_BIT];
                        next_st.digit_carry = wv[DIGIT_CARRY_BIT];
                        next_st.zero = wv[ZERO_BIT];
                    end else begin
                        resp = RESP_SLVERR;
                    end
                end
                INTCTL_OFS: begin
                    if (st.wstrb[0]) next_st.global_interrupt_enable = st.wdata[INT_ENABLE_BIT];
                end
                PC_OFS: begin
                    wv = merge({19'h0, st.pc}, st.wdata, st.wstrb);
                    if (idle) next_st.pc = wv[12:0];
                    else resp = RESP_SLVERR;
                end
                STACK_OFS: begin
                    // Push wraps like the hardware stack, oldest entry is lost
                    wv = merge({19'h0, stack_top}, st.wdata, st.wstrb);
                    if (idle) begin
                        next_st.stack[st.sp] = wv[12:0];
                        next_st.sp = st.sp + 3'd1;
                    end else begin
                        resp = RESP_SLVERR;
                    end
                end
                FILE_ADDR_OFS: begin
                    if (st.wstrb[0]) next_st.file_addr = st.wdata[FILE_AW-1:0];
                end
                FILE_DATA_OFS: begin
                    if (idle && st.wstrb[0]) begin
                        next_st.mem_we = 1'b1;
                        next_st.mem_waddr = st.file_addr;
                        next_st.mem_wdata = st.wdata[7:0];
                    end else if (!idle) begin
                        resp = RESP_SLVERR;
                    end
                end
                WAKE_OFS: begin
                    if (st.state == ST_ASLEEP) begin
                        next_st.state = ST_IDLE;
                        next_st.sleeping = 1'b0;
                    end
                end
                default: resp = RESP_DECERR;
            endcase
            next_st.rsp.bresp = resp;
        end

        // Read channel
        if (st.rsp.rvalid && AXI_REQ_I.rready) begin
            next_st.rsp.rvalid = 1'b0;
        end
        if (st.rd_wait == 2'd2) begin
            next_st.rd_wait = 2'd1;
        end else if (st.rd_wait == 2'd1) begin
            next_st.rd_wait = 2'd0;
            next_st.rsp.rvalid = 1'b1;
            next_st.rsp.rdata = {24'h0, mem_rdata};
            next_st.rsp.rresp = RESP_OKAY;
        end
        if (AXI_REQ_I.arvalid && st.rsp.arready) begin
            resp = RESP_OKAY;
            case (AXI_REQ_I.araddr)
                INSN_OFS: rv = {18'h0, st.insn};
                WORK_OFS: rv = {24'h0, st.work};
                STATUS_OFS: begin
                    rv[CARRY_BIT] = st.carry;
                    rv[DIGIT_CARRY_BIT] = st.digit_carry;
                    rv[ZERO_BIT] = st.zero;
                    rv[POWER_DOWN_BIT] = st.power_down_flag_n;
                    rv[TIME_OUT_BIT] = st.time_out_flag_n;
                    rv[BUSY_BIT] = !idle;
                    rv[SLEEP_BIT] = st.sleeping;
                end
                INTCTL_OFS: rv[INT_ENABLE_BIT] = st.global_interrupt_enable;
                PC_OFS: rv = {19'h0, st.pc};
                STACK_OFS: rv = {13'h0, st.sp, 3'h0, stack_top};
                FILE_ADDR_OFS: rv = {25'h0, st.file_addr};
                FILE_DATA_OFS: begin
                    // Memory port belongs to the engine while it runs
                    if (idle && next_st.state == ST_IDLE) begin
                        next_st.mem_addr = st.file_addr;
                        next_st.rd_wait = 2'd2;
                    end else begin
                        resp = RESP_SLVERR;
                    end
                end
                WATCHDOG_OFS: rv = {16'h0, st.watchdog_prescale, st.watchdog_counter};
                WAKE_OFS: rv = '0;
                default: resp = RESP_DECERR;
            endcase
            if (next_st.rd_wait != 2'd2) begin
                next_st.rsp.rvalid = 1'b1;
                next_st.rsp.rdata = rv;
                next_st.rsp.rresp = resp;
            end
        end

        // Execution engine
        case (st.state)
            ST_IDLE: begin
            end
            ST_FETCH: begin
                next_st.state = ST_EXEC;
            end
            ST_EXEC: begin
                next_st.state = ST_IDLE;
                next_st.pc = st.pc + 13'h0001;
                if (st.insn[13:12] == 2'b00) begin
                    case (st.insn[13:8])
                        INCREMENT_FILE_OP: begin
                            res = f + 8'h01;
                            upd_zero = 1'b1;
                        end
                        OR_WORK_WITH_FILE_OP: begin
                            res = st.work | f;
                            upd_zero = 1'b1;
                        end
                        MOVE_FILE_OP: begin
                            res = f;
                            upd_zero = 1'b1;
                        end
                        SUBTRACT_FROM_FILE_OP: begin
                            res = f - st.work;
                            upd_zero = 1'b1;
                            next_st.carry = (st.work <= f);
                            next_st.digit_carry = (st.work[3:0] <= f[3:0]);
                        end
                        NIBBLE_SWAP_OP: res = {f[3:0], f[7:4]};
                        XOR_WORK_WITH_FILE_OP: begin
                            res = st.work ^ f;
                            upd_zero = 1'b1;
                        end
                        ROTATE_RIGHT_CARRY_OP: begin
                            res = {st.carry, f[7:1]};
                            next_st.carry = f[0];
                        end
                        default: ;
                    endcase
                    // Byte ops choose destination from bit 7
                    to_file = st.insn[7];
                    to_work = !st.insn[7];
                    if (st.insn[13:8] == STORE_WORK_TO_FILE_OP) begin
                        to_work = 1'b0;
                        to_file = st.insn[7];
                        res = st.work;
                        if (st.insn == INTERRUPT_RETURN_OP) begin
                            pop = 1'b1;
                            next_st.global_interrupt_enable = 1'b1;
                        end else if (st.insn == SUBROUTINE_RETURN_OP) begin
                            pop = 1'b1;
                        end else if (st.insn == SLEEP_OP) begin
                            next_st.watchdog_counter = 8'h00;
                            next_st.watchdog_prescale = 8'h00;
                            next_st.time_out_flag_n = 1'b1;
                            next_st.power_down_flag_n = 1'b0;
                            next_st.sleeping = 1'b1;
                            next_st.state = ST_ASLEEP;
                        end
                    end
                end else if (st.insn[13:12] == 2'b11) begin
                    to_work = 1'b1;
                    if (st.insn[13:10] == LOAD_LITERAL_OP) begin
                        res = k;
                    end else if (st.insn[13:10] == RETURN_WITH_LITERAL_OP) begin
                        res = k;
                        pop = 1'b1;
                    end else if (st.insn[13:9] == SUBTRACT_FROM_LITERAL_OP) begin
                        res = k - st.work;
                        upd_zero = 1'b1;
                        next_st.carry = (st.work <= k);
                        next_st.digit_carry = (st.work[3:0] <= k[3:0]);
                    end else if (st.insn[13:8] == XOR_LITERAL_OP) begin
                        res = st.work ^ k;
                        upd_zero = 1'b1;
                    end else begin
                        to_work = 1'b0;
                    end
                end
                if (to_work) begin
                    next_st.work = res;
                end
                if (to_file) begin
                    next_st.mem_we = 1'b1;
                    next_st.mem_waddr = st.insn[FILE_AW-1:0];
                    next_st.mem_wdata = res;
                end
                if (upd_zero) begin
                    next_st.zero = (res == 8'h00);
                end
                if (pop) begin
                    // Program counter changes, so a dead second cycle follows
                    next_st.pc = stack_top;
                    next_st.sp = sp_dec;
                    next_st.state = ST_SECOND;
                end
            end
            ST_SECOND: begin
                next_st.state = ST_IDLE;
            end
            ST_ASLEEP: begin
            end
            default: next_st.state = ST_IDLE;
        endcase

        next_st.rsp.awready = !next_st.aw_held;
        next_st.rsp.wready = !next_st.w_held;
        next_st.rsp.arready = !next_st.rsp.rvalid && next_st.rd_wait == 2'd0;
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            st <= '0;
            st.state <= ST_IDLE;
            st.work <= WORK_RESET;
            st.pc <= PC_RESET;
            st.power_down_flag_n <= POWER_DOWN_RESET;
            st.time_out_flag_n <= TIME_OUT_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign AXI_RSP_O = st.rsp;
    assign SLEEP_O = st.sleeping;
    assign INT_ENABLE_O = st.global_interrupt_enable;
endmodule

// ---- verif/insn_exec_asserts.sv ----
// Port-level assertions for the instruction execute core
`timescale 1ns/10ps
module insn_exec_asserts (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_N_I,
    // Bus and core status
    input wire exec_pkg::axi_req_t AXI_REQ_I,
    input wire exec_pkg::axi_rsp_t AXI_RSP_O,
    input wire logic SLEEP_O,
    input wire logic INT_ENABLE_O
);
    import exec_pkg::*;
    axi_req_t q;
    axi_rsp_t s;
    assign q = AXI_REQ_I;
    assign s = AXI_RSP_O;
    wire aw_t = q.awvalid && s.awready && q.wvalid && s.wready;
    wire ar_t = q.arvalid && s.arready;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    // Accepted opcode write: both halves taken, then an OKAY answer
    sequence insn_ok(code);
        aw_t && q.awaddr == INSN_OFS && q.wdata[13:0] == code ##2 s.bvalid && s.bresp == RESP_OKAY;
    endsequence
    a_sleep_entry: assert property (insn_ok(SLEEP_OP) |-> ##[1:3] SLEEP_O)
        else $error("sleep not entered");
    a_sleep_exit: assert property ($fell(SLEEP_O) |->
        !$past(RST_N_I) || $past(q.awaddr, 2) == WAKE_OFS) else $error("sleep left early");
    a_enable_return: assert property (insn_ok(INTERRUPT_RETURN_OP) |->
        ##[1:4] INT_ENABLE_O) else $error("enable not set");
    a_read_fast: assert property (ar_t && q.araddr != FILE_DATA_OFS |=> s.rvalid)
        else $error("read answer late");
    // Refused file reads answer at once, accepted ones after the memory stage
    a_read_file: assert property (ar_t && q.araddr == FILE_DATA_OFS |=>
        (s.rvalid && s.rresp == RESP_SLVERR) or (!s.rvalid [*2] ##1 s.rvalid))
        else $error("file read timing");
    a_read_decerr: assert property (ar_t && q.araddr > WAKE_OFS |=>
        s.rresp == RESP_DECERR && s.rdata == 32'h0) else $error("unmapped read answer");
    a_write_decerr: assert property (aw_t && q.awaddr > WAKE_OFS |->
        ##2 s.bvalid && s.bresp == RESP_DECERR) else $error("unmapped write answer");
    a_ar_blocked: assert property (ar_t |=> !s.arready ##1
        (!s.arready || $past(s.rvalid && q.rready))) else $error("arready early");
    a_write_answer: assert property (aw_t |=> !s.awready && !s.wready ##1 s.bvalid)
        else $error("write answer timing");
    a_reset_idle: assert property (disable iff (1'b0) !RST_N_I |=>
        !s.bvalid && !s.rvalid && !SLEEP_O && !INT_ENABLE_O) else $error("outputs not idle");
endmodule

bind insn_exec_core insn_exec_asserts u_insn_exec_asserts (
    .CLK_I(CLK_I),
    .RST_N_I(RST_N_I),
    .AXI_REQ_I(AXI_REQ_I),
    .AXI_RSP_O(AXI_RSP_O),
    .SLEEP_O(SLEEP_O),
    .INT_ENABLE_O(INT_ENABLE_O)
);

// ---- verif/test_cpu_instruction_execute_subset.sv ----
// Register-level testbench for the instruction execute core
`timescale 1ns/10ps
module test_cpu_instruction_execute_subset;
    import exec_pkg::*;
    logic CLK_I;
    logic RST_N_I;
    axi_req_t q;
    axi_rsp_t s;
    logic SLEEP_O;
    logic INT_ENABLE_O;
    int failures;
    int tests_run;
    int polls;
    logic [31:0] d;
    logic [1:0] r;
    logic [63:0] t;
    // Opcode, work, file, flags in; work, file, flags out
    localparam logic [63:0] TBL [14] = '{
        64'h0a05_11_ff_00_00_ff_04,
        64'h0a85_11_7f_00_11_80_00,
        64'h0405_0f_f0_04_ff_f0_00,
        64'h0885_12_00_00_12_00_04,
        64'h0085_a5_00_07_a5_a5_07,
        64'h303c_00_01_05_3c_01_05,
        64'h0c05_00_81_00_40_81_01,
        64'h0c85_33_02_07_33_81_06,
        64'h3c10_11_00_07_ff_00_00,
        64'h3c25_25_00_00_00_00_07,
        64'h0285_01_10_00_01_0f_01,
        64'h3aff_0f_00_04_f0_00_00,
        64'h0e05_00_3c_05_c3_3c_05,
        64'h0685_5a_5a_00_5a_00_04
    };
    insn_exec_core u_insn_exec_core (
        .CLK_I(CLK_I),
        .RST_N_I(RST_N_I),
        .AXI_REQ_I(q),
        .AXI_RSP_O(s),
        .SLEEP_O(SLEEP_O),
        .INT_ENABLE_O(INT_ENABLE_O)
    );
    always #10 CLK_I = ~CLK_I;
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic finish_test;
        if (failures == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Values read right after an edge are those the design sampled
    task automatic tick(inout int n);
        @(posedge CLK_I);
        n++;
        if (n > 60) begin
            chk("timeout", 32'h0, 32'h1);
            finish_test();
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] v, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge CLK_I);
        q.awvalid <= 1'b1;
        q.awaddr <= a;
        q.wvalid <= 1'b1;
        q.wdata <= v;
        q.wstrb <= 4'hf;
        q.bready <= 1'b1;
        do begin
            tick(n);
            if (s.awready) q.awvalid <= 1'b0;
            if (s.wready) q.wvalid <= 1'b0;
        end while (!s.bvalid);
        q.bready <= 1'b0;
        chk("bresp", 32'(s.bresp), 32'(er));
    endtask
    task automatic rd(input logic [5:0] a, output logic [31:0] v, output logic [1:0] rr);
        int n;
        n = 0;
        @(posedge CLK_I);
        q.arvalid <= 1'b1;
        q.araddr <= a;
        q.rready <= 1'b1;
        do begin
            tick(n);
            if (s.arready) q.arvalid <= 1'b0;
        end while (!s.rvalid);
        v = s.rdata;
        rr = s.rresp;
        q.rready <= 1'b0;
    endtask
    task automatic rdc(input string nm, input logic [5:0] a, input logic [31:0] m,
                       input logic [31:0] e);
        rd(a, d, r);
        chk(nm, d & m, e);
    endtask
    // Busy refuses most writes, so poll it before going on
    // The poll count tells one-cycle ops from those with a dead second cycle
    task automatic run(input logic [13:0] op);
        wr(INSN_OFS, 32'(op), RESP_OKAY);
        for (int i = 1; i <= 10; i++) begin
            rd(STATUS_OFS, d, r);
            polls = i;
            if (d[BUSY_BIT] === 1'b0) return;
        end
        chk("busy", 32'h1, 32'h0);
        finish_test();
    endtask
    initial begin
        CLK_I = 1'b0;
        RST_N_I = 1'b0;
        q = '0;
        failures = 0;
        tests_run = 0;
        polls = 0;
        repeat (16) @(posedge CLK_I);
        RST_N_I <= 1'b1;
        rdc("status", STATUS_OFS, 32'h3f, 32'h18);
        wr(FILE_ADDR_OFS, 32'h5, RESP_OKAY);
        for (int i = 0; i < 14; i++) begin
            t = TBL[i];
            wr(WORK_OFS, 32'(t[47:40]), RESP_OKAY);
            wr(FILE_DATA_OFS, 32'(t[39:32]), RESP_OKAY);
            wr(STATUS_OFS, 32'(t[31:24]), RESP_OKAY);
            run(t[61:48]);
            chk("cycles", 32'(polls), 32'h1);
            rdc("work", WORK_OFS, 32'hff, 32'(t[23:16]));
            rdc("file", FILE_DATA_OFS, 32'hff, 32'(t[15:8]));
            rdc("flags", STATUS_OFS, 32'h7, 32'(t[7:0]));
        end
        chk("int enable", 32'(INT_ENABLE_O), 32'h0);
        wr(STACK_OFS, 32'h0123, RESP_OKAY);
        run(SUBROUTINE_RETURN_OP);
        chk("cycles", 32'(polls), 32'h2);
        rdc("pc", PC_OFS, 32'h1fff, 32'h0123);
        rdc("sp", STACK_OFS, 32'h70000, 32'h0);
        wr(STACK_OFS, 32'h0456, RESP_OKAY);
        run(14'h34ab);
        chk("cycles", 32'(polls), 32'h2);
        rdc("pc", PC_OFS, 32'h1fff, 32'h0456);
        rdc("work", WORK_OFS, 32'hff, 32'hab);
        wr(STACK_OFS, 32'h0789, RESP_OKAY);
        run(INTERRUPT_RETURN_OP);
        rdc("pc", PC_OFS, 32'h1fff, 32'h0789);
        chk("int enable", 32'(INT_ENABLE_O), 32'h1);
        rdc("int control", INTCTL_OFS, 32'h80, 32'h80);
        wr(INSN_OFS, 32'(SLEEP_OP), RESP_OKAY);
        repeat (4) @(posedge CLK_I);
        chk("sleep", 32'(SLEEP_O), 32'h1);
        rdc("status", STATUS_OFS, 32'h18, 32'h10);
        rdc("watchdog", WATCHDOG_OFS, 32'hff, 32'h0);
        chk("prescaler", 32'(d[15:8] < 8'h20), 32'h1);
        rd(FILE_DATA_OFS, d, r);
        chk("file rresp", 32'(r), 32'(RESP_SLVERR));
        wr(INSN_OFS, 32'h303c, RESP_SLVERR);
        wr(WAKE_OFS, 32'h0, RESP_OKAY);
        @(posedge CLK_I);
        chk("sleep", 32'(SLEEP_O), 32'h0);
        rdc("work", WORK_OFS, 32'hff, 32'hab);
        wr(6'h28, 32'h1, RESP_DECERR);
        rd(6'h3c, d, r);
        chk("rresp", 32'(r), 32'(RESP_DECERR));
        chk("rdata", d, 32'h0);
        finish_test();
    end
endmodule
